//--- core/gplm_pkg.sv
`default_nettype none
// ============================================================
// shared constants for the pin mux and led logic
package gplm_pkg;
    // number of multiplexed pins
    localparam int GPLM_PINS = 3;
    // wishbone address and data widths
    localparam int GPLM_AW = 8;
    localparam int GPLM_DW = 32;
    // register byte offsets
    localparam logic [7:0] GPLM_ADR_CFG = 8'h00;
    localparam logic [7:0] GPLM_ADR_DATA = 8'h04;
    localparam logic [7:0] GPLM_ADR_STAT = 8'h08;
    // config field positions: direction, open drain, led select
    localparam int GPLM_CFG_DIR_LSB = 0;
    localparam int GPLM_CFG_OD_LSB = 8;
    localparam int GPLM_CFG_LED_LSB = 16;
    // data field positions: output data, synchronised pin level
    localparam int GPLM_DATA_OUT_LSB = 0;
    localparam int GPLM_DATA_IN_LSB = 16;
    // status bit positions
    localparam int GPLM_STAT_LINK = 0;
    localparam int GPLM_STAT_SPEED = 1;
    localparam int GPLM_STAT_DUPLEX = 2;
    localparam int GPLM_STAT_DARK = 3;
    // reset values
    localparam logic [31:0] GPLM_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] GPLM_DATA_RST = 32'h0000_0000;
    // blink timing
    localparam int GPLM_CLK_HZ = 50_000_000;
    localparam int GPLM_BLINK_MS = 80;
    localparam int GPLM_BLINK_CYCLES = GPLM_BLINK_MS * (GPLM_CLK_HZ / 1000);
    // blink sequencer states
    typedef enum logic [1:0] {BL_SOLID, BL_DARK, BL_HOLD} gplm_blink_type;
endpackage
`default_nettype wire

//--- core/gplm_blink_if.sv
`default_nettype none
// ============================================================
// link state in, activity in, led state out
interface gplm_blink_if;
    logic linkUp;
    logic activity;
    logic ledOn;
    logic dark;
    modport ctrl (output linkUp, output activity, input ledOn, input dark);
    modport blink (input linkUp, input activity, output ledOn, output dark);
endinterface
`default_nettype wire

//--- core/gplm_blink.sv
`default_nettype none
// ============================================================
// link and activity led sequencer: solid, dark pulse, solid hold
module gplm_blink
    import gplm_pkg::*;
#(
    parameter int BLINK_CYCLES = GPLM_BLINK_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst,
    gplm_blink_if.blink bl
);
    localparam int CW = $clog2(BLINK_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(BLINK_CYCLES - 1);

    gplm_blink_type state_r, state_nxt;
    logic [CW-1:0] count_r, count_nxt;
    logic pending_r, pending_nxt;
    wire logic expired = (count_r == '0);
    wire logic startDark = (state_r == BL_SOLID) && bl.linkUp
        && (bl.activity || pending_r);

    // ============================================================
    // next state: no dark pulse without a link
    always_comb
    begin
        state_nxt = state_r;
        count_nxt = (count_r == '0) ? count_r : count_r - 1'b1;
        unique case (state_r)
            BL_SOLID:
            begin
                if (startDark)
                begin
                    state_nxt = BL_DARK; // R6
                    count_nxt = LOAD;
                end
            end
            BL_DARK:
            begin
                if (expired)
                begin
                    state_nxt = BL_HOLD; // R7
                    count_nxt = LOAD;
                end
            end
            BL_HOLD:
            begin
                if (expired)
                    state_nxt = BL_SOLID; // R7
            end
        endcase
        if (!bl.linkUp)
        begin
            state_nxt = BL_SOLID;
            count_nxt = '0;
        end
    end

    // activity seen in dark or hold is remembered; the edge that starts
    // a dark pulse consumes it, so one cycle of activity gives one pulse, not two
    assign pending_nxt = bl.linkUp && !startDark
        && (bl.activity || pending_r); // R7

    // ============================================================
    // state registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= BL_SOLID;
            count_r <= '0;
            pending_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            pending_r <= pending_nxt;
        end
    end

    // led lit on any valid link except during the dark pulse
    assign bl.ledOn = bl.linkUp && (state_r != BL_DARK); // R5
    assign bl.dark = (state_r == BL_DARK);
endmodule // gplm_blink
`default_nettype wire

//--- core/gpio_led_pin_mux.sv
// Operation
// R1 - each pin: push-pull, open-drain or input
// R2 - each pin may instead show a led
// R3 - led pins are open drain, low lit
// R4 - speed led lit at 100 Mb/s
// R5 - link led lit whenever link is valid
// R6 - activity darkens link led for 80 ms
// R7 - then lit 80 ms before next dark
// R8 - duplex led lit in full duplex
// R9 - led select overrides gpio settings
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`default_nettype none
// ============================================================
// three gpio pins multiplexed with three status leds
// pin 0 speed led, pin 1 link and activity led, pin 2 duplex led
module gpio_led_pin_mux
    import gplm_pkg::*;
#(
    parameter int BLINK_CYCLES = GPLM_BLINK_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [GPLM_AW-1:0] adr_i,
    input wire logic [GPLM_DW-1:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [GPLM_DW-1:0] dat_o,
    output logic ack_o,
    // link status from mac and phy, same clock
    input wire logic linkUp,
    input wire logic speed100,
    input wire logic fullDuplex,
    input wire logic txActivity,
    input wire logic rxActivity,
    // pins, three signals each
    input wire logic [GPLM_PINS-1:0] gpioIn,
    output logic [GPLM_PINS-1:0] gpioOut,
    output logic [GPLM_PINS-1:0] gpioOe
);

    // ============================================================
    // helpers

    // byte lane merge, used for every writable register
    function automatic logic [31:0] laneMerge(
        input logic [31:0] old,
        input logic [31:0] wr,
        input logic [3:0] sel
    );
        logic [31:0] res;
        // lanes without a select keep the old byte
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                res[8*b +: 8] = wr[8*b +: 8];
        end
        return res;
    endfunction

    // ============================================================
    // declarations
    // register state
    logic [31:0] cfg_r, cfg_nxt;
    logic [31:0] data_r, data_nxt;
    logic ack_r;
    logic [31:0] rdat_r, rdat_nxt;
    // pin input synchroniser stages
    logic [GPLM_PINS-1:0] sync1_r;
    logic [GPLM_PINS-1:0] sync2_r;
    // pin drive
    logic [GPLM_PINS-1:0] pinOut_r, pinOut_nxt;
    logic [GPLM_PINS-1:0] pinOe_r, pinOe_nxt;
    // led states and read words
    logic [GPLM_PINS-1:0] ledOn;
    logic [31:0] statWord;
    logic [31:0] dataWord;

    // blink sequencer connection
    gplm_blink_if blIf ();

    // ============================================================
    // bus decode
    wire logic busReq = cyc_i && stb_i;
    // act once per request: the cycle before ack goes high
    wire logic busTake = busReq && !ack_r;
    wire logic busWr = busTake && we_i;
    // reads latch their word at the taking edge only
    wire logic busRd = busTake && !we_i;
    // the byte address is decoded in full; aliases are not hits
    wire logic hitCfg = (adr_i == GPLM_ADR_CFG);
    wire logic hitData = (adr_i == GPLM_ADR_DATA);
    wire logic hitStat = (adr_i == GPLM_ADR_STAT);

    // config fields
    wire logic [GPLM_PINS-1:0] cfgDir =
        cfg_r[GPLM_CFG_DIR_LSB +: GPLM_PINS];
    wire logic [GPLM_PINS-1:0] cfgOd =
        cfg_r[GPLM_CFG_OD_LSB +: GPLM_PINS];
    wire logic [GPLM_PINS-1:0] cfgLed =
        cfg_r[GPLM_CFG_LED_LSB +: GPLM_PINS];
    wire logic [GPLM_PINS-1:0] outData =
        data_r[GPLM_DATA_OUT_LSB +: GPLM_PINS];

    // only implemented bits are writable; the rest read as zero
    // masking at the write keeps the read mux free of masks
    // one bit per pin in each field
    localparam logic [31:0] PIN_BITS = 32'((1 << GPLM_PINS) - 1);
    localparam logic [31:0] CFG_MASK =
        (PIN_BITS << GPLM_CFG_DIR_LSB)
        | (PIN_BITS << GPLM_CFG_OD_LSB)
        | (PIN_BITS << GPLM_CFG_LED_LSB);
    localparam logic [31:0] DATA_MASK =
        PIN_BITS << GPLM_DATA_OUT_LSB;

    // ============================================================
    // register writes, byte lanes honoured; a write lands at its
    // taking edge, so a read issued right after sees the new value
    wire logic wrCfg = busWr && hitCfg;
    wire logic wrData = busWr && hitData;
    assign cfg_nxt = wrCfg
        ? (laneMerge(cfg_r, dat_i, sel_i) & CFG_MASK) : cfg_r; // R1
    assign data_nxt = wrData
        ? (laneMerge(data_r, dat_i, sel_i) & DATA_MASK) : data_r;

    // ============================================================
    // read words: data shows written output bits and pin levels
    always_comb
    begin
        dataWord = data_r;
        dataWord[GPLM_DATA_IN_LSB +: GPLM_PINS] = sync2_r;
    end

    // status shows the live link state and the blink phase
    // live bits, not latched: software sees the level at the read edge
    always_comb
    begin
        statWord = 32'h0000_0000;
        statWord[GPLM_STAT_LINK] = linkUp;
        statWord[GPLM_STAT_SPEED] = speed100;
        statWord[GPLM_STAT_DUPLEX] = fullDuplex;
        statWord[GPLM_STAT_DARK] = blIf.dark;
    end

    // one select per register; unmapped addresses are acked, read zero
    wire logic [31:0] rdCfg = hitCfg ? cfg_r : 32'h0000_0000;
    wire logic [31:0] rdData = hitData ? dataWord : 32'h0000_0000;
    wire logic [31:0] rdStat = hitStat ? statWord : 32'h0000_0000;
    // the hits are exclusive, so an or of the selects is the mux
    assign rdat_nxt = busRd ? (rdCfg | rdData | rdStat) : 32'h0000_0000;

    // ============================================================
    // configuration register; reset makes every pin an input
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cfg_r <= GPLM_CFG_RST;
        else
            cfg_r <= cfg_nxt;
    end

    // ============================================================
    // output data register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            data_r <= GPLM_DATA_RST;
        else
            data_r <= data_nxt;
    end

    // ============================================================
    // ack: one wait state, drops after one cycle even if stb stays
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= busTake;
    end

    // ============================================================
    // read data register: zero outside the ack cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rdat_r <= 32'h0000_0000;
        else
            rdat_r <= rdat_nxt;
    end

    // ============================================================
    // pin input synchroniser; schmitt pads still need two flops
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sync1_r <= '0;
        else
            sync1_r <= gpioIn;
    end

    // second stage is the only reader of the first; pin levels lag two
    // edges, so a read right after a write still shows the old level
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sync2_r <= '0;
        else
            sync2_r <= sync1_r;
    end

    // ============================================================
    // link and activity blink sequencer
    // status inputs share the device clock, so they need no synchroniser
    // link drop returns the sequencer to solid at once
    assign blIf.linkUp = linkUp;
    assign blIf.activity = txActivity || rxActivity; // R6

    gplm_blink #(
        .BLINK_CYCLES(BLINK_CYCLES)
    ) u_blink (
        .ref_clk(ref_clk),
        .rst(rst),
        .bl(blIf)
    );

    // ============================================================
    // led states, active low names for the pin level
    wire logic speed_led_n = !(linkUp && speed100); // R4
    wire logic link_activity_led_n = !blIf.ledOn; // R5
    // half duplex or no link leaves the led dark
    wire logic duplex_led_n = !(linkUp && fullDuplex); // R8

    // pin order: speed, link and activity, duplex
    assign ledOn[0] = !speed_led_n;
    assign ledOn[1] = !link_activity_led_n;
    assign ledOn[2] = !duplex_led_n;

    // ============================================================
    // per pin mux; open drain never drives high, avoiding contention
    // with other open drain drivers on the same net
    generate
        for (genvar p = 0; p < GPLM_PINS; p++)
        begin : g_pin
            // push-pull drive
            wire logic ppOut = outData[p];
            wire logic ppOe = cfgDir[p];
            // open drain: output stays low, enable carries the data
            wire logic odOe = cfgDir[p] && !outData[p];
            // led: low while lit, released while dark
            wire logic ledOe = ledOn[p]; // R3
            // the enable alone decides the pin in led and open drain
            // modes; led select wins over direction, type and data
            assign pinOut_nxt[p] = (cfgLed[p] || cfgOd[p]) // R9
                ? 1'b0 : ppOut; // R1
            assign pinOe_nxt[p] = cfgLed[p] ? ledOe // R9
                : (cfgOd[p] ? odOe : ppOe); // R1
        end
    endgenerate

    // ============================================================
    // pin output value; reset leaves every pin released
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pinOut_r <= '0;
        else
            pinOut_r <= pinOut_nxt; // R2
    end

    // ============================================================
    // pin enable; released at reset, safe on a shared net
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pinOe_r <= '0;
        else
            pinOe_r <= pinOe_nxt;
    end

    // ============================================================
    // outputs straight from flops
    // nothing combinational reaches a pin or the bus
    assign gpioOut = pinOut_r;
    assign gpioOe = pinOe_r;
    assign dat_o = rdat_r;
    assign ack_o = ack_r;

endmodule // gpio_led_pin_mux
`default_nettype wire

//--- sim/gplm_board.sv
`default_nettype none
// ============================================================
// board side: pull-ups on the pins, optional driver, led per pin
module gplm_board
    import gplm_pkg::*;
(
    input wire logic [GPLM_PINS-1:0] gpioOut,
    input wire logic [GPLM_PINS-1:0] gpioOe,
    input wire logic [GPLM_PINS-1:0] extVal,
    input wire logic [GPLM_PINS-1:0] extOe,
    output logic [GPLM_PINS-1:0] pinLevel,
    output logic [GPLM_PINS-1:0] ledLit
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released pin with extOe low goes to the pull-up level, never its last value
    assign pinLevel = (gpioOe & gpioOut) | (~gpioOe & extOe & extVal)
        | (~gpioOe & ~extOe);
    // led hangs from the supply, so it lights when the pin is low
    assign ledLit = ~pinLevel;
endmodule // gplm_board
`default_nettype wire

//--- sim/gplm_chk.sv
`default_nettype none
// ============================================================
// port checker: bus handshake and led pin timing
module gplm_chk
    import gplm_pkg::*;
#(
    parameter int BLINK_CYCLES = GPLM_BLINK_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [GPLM_AW-1:0] adr_i,
    input wire logic [GPLM_DW-1:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic [GPLM_DW-1:0] dat_o,
    input wire logic ack_o,
    input wire logic linkUp,
    input wire logic speed100,
    input wire logic fullDuplex,
    input wire logic [GPLM_PINS-1:0] gpioOut,
    input wire logic [GPLM_PINS-1:0] gpioOe
);
    logic [2:0] ledSel_r;
    logic lk;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // shadow of the led select field, taken at the write's taking edge
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ledSel_r <= 3'h0;
        else if (cyc_i && stb_i && we_i && !ack_o && sel_i[2]
                 && adr_i == GPLM_ADR_CFG)
            ledSel_r <= dat_i[18:16];
    end
    assign lk = ledSel_r[1] && linkUp;
    // ============================================================
    // assertions
    a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_idle_data_zero: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_led_open_drain: assert property ((ledSel_r & $past(ledSel_r) & gpioOut) == 3'h0)
        else $error("led pin drives high");
    a_speed_led: assert property (ledSel_r[0] && $past(ledSel_r[0]) |-> gpioOe[0] == $past(linkUp && speed100))
        else $error("speed led wrong");
    a_duplex_led: assert property (ledSel_r[2] && $past(ledSel_r[2]) |-> gpioOe[2] == $past(linkUp && fullDuplex))
        else $error("duplex led wrong");
    a_link_off: assert property (ledSel_r[1] && $past(ledSel_r[1], 3) && !$past(linkUp, 2) && !$past(linkUp, 3) |-> !gpioOe[1])
        else $error("link led lit without link");
    a_dark_len: assert property ($fell(gpioOe[1]) && lk && $past(lk) |=> (!gpioOe[1] || !linkUp) [*7] ##1 (gpioOe[1] || !linkUp))
        else $error("dark pulse length wrong");
    a_hold_len: assert property ($rose(gpioOe[1]) && lk && $past(lk, 8) |=> (gpioOe[1] || !linkUp) [*7])
        else $error("lit gap too short");
    c_dark: cover property ($fell(gpioOe[1]) && lk);
    c_write: cover property (ack_o && we_i);
    c_duplex: cover property (ledSel_r[2] && gpioOe[2]);
endmodule // gplm_chk
`default_nettype wire

//--- sim/gpio_led_pin_mux_tb_top.sv
`default_nettype none
// ============================================================
// self-checking bench for the pin mux and status leds
module gpio_led_pin_mux_tb_top
    import gplm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short blink keeps the run brief
    localparam int NBLINK = 8;
    logic ref_clk, rst, cyc, stb, we, ack, linkUp, speed100, fullDuplex;
    logic txAct, rxAct;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] datW, datR, q;
    logic [2:0] pinLevel, gpioOut, gpioOe, extVal, extOe, ledLit;
    int num_errors = 0;
    int tests_run = 0;
    int n;
    gpio_led_pin_mux #(.BLINK_CYCLES(NBLINK)) uut (.ref_clk(ref_clk),
        .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(datW), .sel_i(sel), .dat_o(datR), .ack_o(ack),
        .linkUp(linkUp), .speed100(speed100), .fullDuplex(fullDuplex),
        .txActivity(txAct), .rxActivity(rxAct), .gpioIn(pinLevel),
        .gpioOut(gpioOut), .gpioOe(gpioOe));
    gplm_board board (.gpioOut(gpioOut), .gpioOe(gpioOe), .extVal(extVal),
        .extOe(extOe), .pinLevel(pinLevel), .ledLit(ledLit));
    // ============================================================
    // tasks
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // classic cycle: request held until ack is sampled, no latency assumed
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge ref_clk);
        {cyc, stb, we, adr, datW, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        r = datR;
        {cyc, stb} <= 2'h0;
        if (k >= 20)
        begin
            num_errors++;
            wrap_up();
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    // edges until the link led pin enable leaves level v, bounded
    task automatic run_len(input logic v, output int cnt);
        cnt = 0;
        while (gpioOe[1] === v && cnt < 50)
        begin
            tick(1);
            cnt++;
        end
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ============================================================
    // main sequence
    initial
    begin
        {rst, cyc, stb, we, adr, datW, sel} = {4'h8, 8'h0, 32'h0, 4'h0};
        {linkUp, speed100, fullDuplex, txAct, rxAct} = 5'h0;
        {extVal, extOe} = 6'h0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'b0, GPLM_ADR_CFG, 32'h0, q);
        check(q, GPLM_CFG_RST);
        xfer(1'b0, GPLM_ADR_DATA, 32'h0, q);
        check(q, 32'h0007_0000);
        xfer(1'b0, 8'h0c, 32'h0, q);
        check(q, 32'h0);
        $display("reset test done");
        xfer(1'b1, GPLM_ADR_DATA, 32'h5, q);
        xfer(1'b1, GPLM_ADR_CFG, 32'h7, q);
        tick(2);
        check(32'(gpioOe), 32'h7);
        check(32'(gpioOut), 32'h5);
        xfer(1'b1, GPLM_ADR_CFG, 32'h0707, q);
        xfer(1'b1, GPLM_ADR_DATA, 32'h2, q);
        tick(3);
        check(32'(gpioOe), 32'h5);
        check(32'(gpioOut), 32'h0);
        xfer(1'b0, GPLM_ADR_DATA, 32'h0, q);
        check(q, 32'h0002_0002);
        xfer(1'b1, GPLM_ADR_CFG, 32'h0, q);
        @(posedge ref_clk);
        {extOe, extVal} <= 6'h3d;
        tick(3);
        xfer(1'b0, GPLM_ADR_DATA, 32'h0, q);
        check(q, 32'h0005_0002);
        $display("gpio test done");
        @(posedge ref_clk);
        {extOe, linkUp, speed100} <= 5'h03;
        xfer(1'b1, GPLM_ADR_CFG, 32'h0007_0707, q);
        tick(3);
        check(32'(gpioOe), 32'h3);
        check(32'(gpioOut), 32'h0);
        check(32'(ledLit), 32'h3);
        @(posedge ref_clk);
        {speed100, fullDuplex} <= 2'h1;
        tick(3);
        check(32'(gpioOe), 32'h6);
        xfer(1'b0, GPLM_ADR_STAT, 32'h0, q);
        check(q, 32'h5);
        $display("led test done");
        @(posedge ref_clk);
        txAct <= 1'b1;
        @(posedge ref_clk);
        txAct <= 1'b0;
        #1;
        run_len(1'b1, n);
        // activity during the dark phase must queue the next pulse
        @(posedge ref_clk);
        rxAct <= 1'b1;
        @(posedge ref_clk);
        rxAct <= 1'b0;
        #1;
        run_len(1'b0, n);
        check(32'(n + 2), NBLINK);
        // one solid edge passes between hold and the queued dark
        run_len(1'b1, n);
        check(32'(n), NBLINK + 1);
        run_len(1'b0, n);
        check(32'(n), NBLINK);
        // the queued pulse is used up: no third dark
        run_len(1'b1, n);
        check(32'(n), 32'd50);
        $display("blink test done");
        @(posedge ref_clk);
        linkUp <= 1'b0;
        tick(4);
        check(32'(gpioOe), 32'h0);
        $display("link drop test done");
        wrap_up();
    end
endmodule // gpio_led_pin_mux_tb_top
bind gpio_led_pin_mux gplm_chk #(.BLINK_CYCLES(BLINK_CYCLES)) chk (
    .ref_clk(ref_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .linkUp(linkUp), .speed100(speed100),
    .fullDuplex(fullDuplex), .gpioOut(gpioOut), .gpioOe(gpioOe));
`default_nettype wire
